// File: verification/dcsc_host_model.sv
// host bus master model: grants the hold request after a delay
// assumes the bench raises drop to take the bus back for a while
`timescale 1ns/1ps
module dcsc_host_model #(
  parameter int LAT = 2
)(
  // handshake
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic hold_req,
  input  wire logic drop,
  output logic      hold_ack
);
  logic [7:0] req_q;
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      req_q <= 8'h0;
    else
      req_q <= {req_q[6:0], hold_req};
  end
  // drop takes the bus back at once, as a refresh master would
  assign hold_ack = req_q[LAT-1] && !drop;
endmodule

// File: verification/dcsc_top_assertions.sv
// checker for the dma service control block, bound to its top module
// assumes one clock and an active-low asynchronous reset
`timescale 1ns/1ps
module dcsc_top_assertions
  import dcsc_pkg::*;
#(
  parameter int AW = 24
)(
  // clock and reset
  input wire logic           CLK,
  input wire logic           RSTN,
  // apb
  input wire logic           PSEL,
  input wire logic           PENABLE,
  input wire logic [7:0]     PADDR,
  input wire logic           PSLVERR,
  // dma
  input wire logic [NCH-1:0] CHANNEL_ACKNOWLEDGE_PIN,
  input wire logic           TERMINAL_COUNT,
  input wire logic           BUS_HOLD_REQUEST,
  input wire logic [AW-1:0]  ADDRESS,
  input wire logic           UPPER_ADDRESS_STATE,
  input wire logic           BUS_WAIT_STATE,
  input wire logic           XFER_STROBE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);
  sequence hold_gap_s;
    !BUS_HOLD_REQUEST [*2];
  endsequence
  ack_onehot_a: assert property ($onehot0(CHANNEL_ACKNOWLEDGE_PIN))
    else $error("more than one channel acknowledged");
  strobe_grant_a: assert property (XFER_STROBE |->
    BUS_HOLD_REQUEST && $onehot(CHANNEL_ACKNOWLEDGE_PIN))
    else $error("transfer without bus grant");
  strobe_gap_a: assert property (XFER_STROBE |=> !XFER_STROBE [*2])
    else $error("transfer shorter than three clocks");
  wait_hold_a: assert property ($rose(BUS_WAIT_STATE) |-> hold_gap_s)
    else $error("hold request not dropped in bus wait");
  wait_quiet_a: assert property (BUS_WAIT_STATE && $past(BUS_WAIT_STATE) |-> !XFER_STROBE)
    else $error("transfer during bus wait");
  term_pulse_a: assert property (TERMINAL_COUNT |=> !TERMINAL_COUNT)
    else $error("terminal count longer than one clock");
  idle_addr_a: assert property (CHANNEL_ACKNOWLEDGE_PIN == 0 |-> ADDRESS == 0)
    else $error("address driven while idle");
  upper_busy_a: assert property (UPPER_ADDRESS_STATE |-> |CHANNEL_ACKNOWLEDGE_PIN)
    else $error("upper address state while idle");
  apb_err_a: assert property (PSEL && PENABLE && PADDR > OFS_STATUS |-> PSLVERR)
    else $error("unmapped access not refused");
endmodule
////////////////////////////////////////
bind dcsc_top dcsc_top_assertions #(.AW(AW)) chk_u (.CLK(CLK), .RSTN(RSTN), .PSEL(PSEL),
  .PENABLE(PENABLE), .PADDR(PADDR), .PSLVERR(PSLVERR),
  .CHANNEL_ACKNOWLEDGE_PIN(CHANNEL_ACKNOWLEDGE_PIN), .TERMINAL_COUNT(TERMINAL_COUNT),
  .BUS_HOLD_REQUEST(BUS_HOLD_REQUEST), .ADDRESS(ADDRESS),
  .UPPER_ADDRESS_STATE(UPPER_ADDRESS_STATE), .BUS_WAIT_STATE(BUS_WAIT_STATE),
  .XFER_STROBE(XFER_STROBE));

// File: verification/dcsc_top_test.sv
// testbench for the dma service control block
// assumes the host model grants hold; end input idle outside its own scenario
`timescale 1ns/1ps
module dcsc_top_test;
  import dcsc_pkg::*;
  logic        clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, drop = 0, end_n = 1;
  logic [7:0]  paddr = 0;
  logic [31:0] pwdata = 0, prdata, v;
  logic        pready, pslverr, term, hreq, hack, lsb, upen_n, ups, bws, stb;
  logic [3:0]  rq_pin = 0, ack;
  logic [23:0] addr, s_addr;
  logic [1:0]  s_lane;
  int          error_cnt = 0, checked = 0, nstb = 0, last = 0, gap = 0, cyc = 0, tgt, k;
  int          nterm = 0;
  always #5 clk = ~clk;
  dcsc_top dut_u (.CLK(clk), .RSTN(rstn), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .CHANNEL_REQUEST_PIN(rq_pin), .CHANNEL_ACKNOWLEDGE_PIN(ack), .END_N(end_n),
    .TERMINAL_COUNT(term), .BUS_HOLD_REQUEST(hreq), .BUS_HOLD_ACKNOWLEDGE(hack),
    .ADDRESS(addr), .ADDRESS_BIT_ZERO(lsb), .UPPER_BYTE_ENABLE_N(upen_n),
    .UPPER_ADDRESS_STATE(ups), .BUS_WAIT_STATE(bws), .XFER_STROBE(stb));
  dcsc_host_model host_u (.clk(clk), .rstn(rstn), .hold_req(hreq), .drop(drop),
    .hold_ack(hack));
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (stb === 1'h1)
    begin
      nstb <= nstb + 1;
      gap <= cyc - last;
      last <= cyc;
      s_addr <= addr;
      s_lane <= {lsb, upen_n};
    end
    if (term === 1'h1)
      nterm <= nterm + 1;
  end
  ////////////////////////////////////////
  task automatic stop_test;
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    checked++;
    if (s !== e)
    begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  // one apb transfer; read data lands in v
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    for (i = 0; i < 20; i++)
    begin
      @(posedge clk);
      if (pready === 1'h1)
        break;
    end
    if (i == 20)
    begin
      error_cnt++;
      stop_test();
    end
    v = prdata;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic prog(input logic [1:0] ch, input logic [7:0] m, input logic [23:0] a,
                      input logic [15:0] c);
    bus(1, OFS_CHSEL, {30'h0, ch});
    bus(1, OFS_MODE, {24'h0, m});
    bus(1, OFS_BADDR, {8'h0, a});
    bus(1, OFS_BCOUNT, {16'h0, c});
  endtask
  // bounded wait: 0 any ack, 1 idle, 2 bus wait, 3 strobe count, 4 channel 3 ack
  task automatic wfor(input int sel);
    int i;
    for (i = 0; i < 400; i++)
    begin
      @(posedge clk);
      #1;
      if (sel == 0 ? |ack : sel == 1 ? ack == 0 : sel == 2 ? bws : sel == 3 ? nstb >= tgt
          : ack[3])
        break;
    end
    if (i == 400)
    begin
      chk("wait", sel, -1);
      stop_test();
    end
  endtask
  ////////////////////////////////////////
  initial
  begin
    repeat (10) @(posedge clk);
    rstn <= 1'h1;
    bus(0, OFS_MASK, 0);
    chk("mask", MASK_RESET, v);
    bus(0, 8'h40, 0);
    chk("unmapped", 0, v);
    bus(1, OFS_MASK, 8);
    bus(1, OFS_DEVCTL, 0);
    prog(1, 8'h0, 24'h200, 0);
    prog(3, 8'h0, 24'h300, 5);
    bus(1, OFS_REQUEST, 32'ha);
    wfor(0);
    chk("first", 4'h2, ack);
    wfor(1);
    bus(0, OFS_REQUEST, 0);
    chk("req", 0, v);
    chk("term", 1, nterm);
    bus(1, OFS_CHSEL, 1);
    bus(0, OFS_CADDR, 0);
    chk("caddr", 24'h201, v);
    bus(0, OFS_CCOUNT, 0);
    chk("ccount", 16'hffff, v);
    bus(0, OFS_MASK, 0);
    chk("mask", 4'ha, v);
    prog(2, 8'h0, 24'h400, 5);
    bus(1, OFS_DEVCTL, 8);
    @(posedge clk);
    rq_pin <= 4'h4;
    // synced pin reaches arbitration one clock before the soft bit lands, so channel 2 wins alone
    bus(1, OFS_REQUEST, 8);
    wfor(0);
    chk("pin", 4'h4, ack);
    @(posedge clk);
    rq_pin <= 4'h0;
    wfor(4);
    wfor(1);
    bus(0, OFS_REQUEST, 0);
    chk("req", 0, v);
    for (k = 0; k < 2; k++)
    begin
      bus(1, OFS_DEVCTL, 1 - k);
      prog(0, 8'h5, 24'h101, 0);
      bus(1, OFS_REQUEST, 1);
      wfor(1);
      wfor(0);
      wfor(1);
      chk("addr", k ? 24'h101 : 24'h100, s_addr);
      chk("lane", k ? 2'h3 : 2'h0, s_lane);
      bus(0, OFS_CADDR, 0);
      chk("reload", 24'h101, v);
    end
    bus(0, OFS_MASK, 0);
    chk("mask", 4'ha, v);
    // compressed only with block transfers
    for (k = 0; k < 2; k++)
    begin
      bus(1, OFS_DEVCTL, k * 2);
      prog(0, 8'h80, 24'h10, 3);
      tgt = nstb + 4;
      bus(1, OFS_REQUEST, 1);
      wfor(3);
      chk("gap", k ? 3 : 4, gap);
      wfor(1);
    end
    bus(1, OFS_DEVCTL, 0);
    prog(0, 8'h80, 24'h20, 7);
    tgt = nstb + 1;
    bus(1, OFS_REQUEST, 1);
    wfor(3);
    tgt = tgt + 7;
    @(posedge clk);
    drop <= 1'h1;
    wfor(2);
    repeat (6) @(posedge clk);
    drop <= 1'h0;
    wfor(3);
    wfor(1);
    // end input cuts an autoinit block short
    prog(0, 8'h84, 24'h30, 16'hff);
    tgt = nstb + 2;
    bus(1, OFS_REQUEST, 1);
    wfor(3);
    @(posedge clk);
    end_n <= 1'h0;
    wfor(1);
    @(posedge clk);
    end_n <= 1'h1;
    bus(0, OFS_CADDR, 0);
    chk("end reload", 24'h30, v);
    bus(0, OFS_CCOUNT, 0);
    chk("end count", 16'hff, v);
    // channel 1 relays a second controller's hold handshake
    bus(1, OFS_MASK, 0);
    prog(1, 8'hc0, 24'h0, 16'h0);
    tgt = nstb;
    @(posedge clk);
    rq_pin <= 4'h2;
    wfor(0);
    chk("casc ack", 4'h2, ack);
    chk("casc addr", 0, addr);
    @(posedge clk);
    rq_pin <= 4'h0;
    wfor(1);
    chk("casc hold", 0, hreq);
    chk("casc xfers", tgt, nstb);
    bus(1, OFS_MASK, 2);
    prog(0, 8'h0, 24'h0, 16'h1);
    bus(1, OFS_REQUEST, 1);
    wfor(0);
    chk("soft after casc", 4'h1, ack);
    wfor(1);
    stop_test();
  end
endmodule

// File: verilog/dcsc_pkg.sv
// package for the four-channel dma service control block
// assumes a single clock domain and apb register access
package dcsc_pkg;
  localparam int NCH = 4;
  // register byte offsets (apb, one word each)
  localparam logic [7:0] OFS_DEVCTL  = 8'h00;
  localparam logic [7:0] OFS_CHSEL   = 8'h04;
  localparam logic [7:0] OFS_MODE    = 8'h08;
  localparam logic [7:0] OFS_BADDR   = 8'h0c;
  localparam logic [7:0] OFS_BCOUNT  = 8'h10;
  localparam logic [7:0] OFS_CADDR   = 8'h14;
  localparam logic [7:0] OFS_CCOUNT  = 8'h18;
  localparam logic [7:0] OFS_REQUEST = 8'h1c;
  localparam logic [7:0] OFS_MASK    = 8'h20;
  localparam logic [7:0] OFS_STATUS  = 8'h24;
  // device control fields
  localparam int DC_WIDE = 0;
  localparam int DC_CMP  = 1;
  localparam int DC_ROT  = 2;
  localparam int DC_BHLD = 3;
  // mode control fields
  localparam int MD_WORD = 0;
  localparam int MD_DIR  = 1;
  localparam int MD_AUTI = 2;
  localparam int MD_TM_LO = 6;
  localparam int MD_TM_HI = 7;
  localparam logic [1:0] TM_SINGLE  = 2'h0;
  localparam logic [1:0] TM_DEMAND  = 2'h1;
  localparam logic [1:0] TM_BLOCK   = 2'h2;
  localparam logic [1:0] TM_CASCADE = 2'h3;
  localparam logic [3:0] MASK_RESET = 4'hf;
  localparam int HOLD_GAP_NS  = 20;
  localparam int CLK_NS       = 10;
  localparam int HOLD_GAP_CYC = HOLD_GAP_NS / CLK_NS;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_HOLD  = 3'b001,
    ST_UPPER = 3'b010,
    ST_S2    = 3'b011,
    ST_S3    = 3'b100,
    ST_S4    = 3'b101,
    ST_WAIT  = 3'b110,
    ST_CASC  = 3'b111
  } dcsc_state_t;
endpackage

// File: verilog/dcsc_top.sv
// dma channel service control: arbitration, address/count stepping, bus sequencing
// assumes apb master on CLK; request pins and hold acknowledge are asynchronous
//
// How it works
// RULE1: step address by 1/2, count down one
// RULE2: word units force even address; a channel chained to in hold mode keeps its odd address
// RULE3: word units only on wide bus
// RULE4: lane select via address bit zero, enable
// RULE5: four clocks normally, three compressed
// RULE6: software uses compressed only where allowed
// RULE7: compressed skips upper state except carry
// RULE8: request register bits ignore mask
// RULE9: release mode clears all request bits
// RULE10: hold mode clears served request bit
// RULE11: software masks cascade before soft requests
// RULE12: soft single/demand end after one unit
// RULE13: autoinit reloads current from base
// RULE14: terminal sets mask unless autoinit
// RULE15: fixed priority zero highest three lowest
// RULE16: rotating makes served channel lowest
// RULE17: mode bits 7,6 both one: cascade
// RULE18: cascade relays hold handshake only
// RULE19: cascade acts release mode, clears requests
// RULE20: lost acknowledge in continuous modes waits
// RULE21: lost acknowledge otherwise returns idle
// RULE22: wait drops hold request two clocks
// RULE23: release mode serves one channel per tenure
// RULE24: soft bit arbitrates like request pin
//
// The register offsets and the APB slave port were left to the implementer.
`timescale 1ns/1ps
module dcsc_top
  import dcsc_pkg::*;
#(
  parameter int AW = 24,
  parameter int CW = 16
)(
  // clock and reset
  input  wire logic          CLK,
  input  wire logic          RSTN,
  // apb slave
  input  wire logic          PSEL,
  input  wire logic          PENABLE,
  input  wire logic          PWRITE,
  input  wire logic [7:0]    PADDR,
  input  wire logic [31:0]   PWDATA,
  output logic      [31:0]   PRDATA,
  output logic               PREADY,
  output logic               PSLVERR,
  // i/o device side
  input  wire logic [NCH-1:0] CHANNEL_REQUEST_PIN,
  output logic      [NCH-1:0] CHANNEL_ACKNOWLEDGE_PIN,
  input  wire logic           END_N,
  output logic                TERMINAL_COUNT,
  // host bus side
  output logic                BUS_HOLD_REQUEST,
  input  wire logic           BUS_HOLD_ACKNOWLEDGE,
  output logic      [AW-1:0]  ADDRESS,
  output logic                ADDRESS_BIT_ZERO,
  output logic                UPPER_BYTE_ENABLE_N,
  output logic                UPPER_ADDRESS_STATE,
  output logic                BUS_WAIT_STATE,
  output logic                XFER_STROBE
);

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers
  logic [NCH-1:0] rq_s1_q, rq_q;
  logic [2:0]     ms1_q, ms_q;
  logic           hack_q, end_q;
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      rq_s1_q <= '0;
      rq_q    <= '0;
      // synced pins reset to their idle levels, end input high
      ms1_q   <= 3'h5;
      ms_q    <= 3'h5;
    end
    else
    begin
      rq_s1_q <= CHANNEL_REQUEST_PIN;
      rq_q    <= rq_s1_q;
      ms1_q   <= {END_N, BUS_HOLD_ACKNOWLEDGE, 1'b1};
      ms_q    <= ms1_q;
    end
  end
  assign hack_q = ms_q[1];
  assign end_q  = ~ms_q[2];

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [3:0]    devctl_q;
  logic [1:0]    chsel_q;
  logic [7:0]    mode_q   [NCH];
  logic [AW-1:0] baddr_q  [NCH];
  logic [AW-1:0] caddr_q  [NCH];
  logic [CW-1:0] bcount_q [NCH];
  logic [CW-1:0] ccount_q [NCH];
  logic [NCH-1:0] soft_q, mask_q, cntend_q;
  dcsc_state_t   st_q;
  logic [1:0]    cur_q, last_q;
  logic          first_q;
  logic [1:0]    gap_q;

  wire wr_en = PSEL && PENABLE && PWRITE;
  wire rd_ok = (PADDR <= OFS_STATUS) && (PADDR[1:0] == 2'h0);
  assign PREADY  = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !rd_ok;

  ////////////////////////////////////////////////////////////////////////////
  // arbitration
  function automatic logic [2:0] pick(input logic [NCH-1:0] req, input logic [1:0] top);
    logic [2:0] r;
    logic [1:0] c;
    r = 3'h4;
    for (int i = NCH - 1; i >= 0; i--)
    begin
      c = top + 2'(i);
      if (req[c])
        r = {1'b0, c};
    end
    return r;
  endfunction

  wire [NCH-1:0] pending = (rq_q & ~mask_q) | soft_q; // [RULE8] [RULE24]
  wire [1:0] top_ch = devctl_q[DC_ROT] ? 2'(last_q + 2'h1) : 2'h0; // [RULE15] [RULE16]
  wire [2:0] win = pick(pending, top_ch);
  wire [1:0] tmode = mode_q[cur_q][MD_TM_HI:MD_TM_LO];
  wire cascade = (tmode == TM_CASCADE); // [RULE17]
  wire is_word = devctl_q[DC_WIDE] && mode_q[cur_q][MD_WORD]; // [RULE3]
  wire hold_mode = devctl_q[DC_BHLD];
  wire cur_req = rq_q[cur_q] && !mask_q[cur_q];
  wire zero_cnt = (ccount_q[cur_q] == '0);
  wire terminal = zero_cnt || end_q;
  wire soft_cur = soft_q[cur_q];
  wire continuous = (tmode == TM_BLOCK) || (tmode == TM_DEMAND && !hold_mode);
  // chaining skips the hold handshake, so a cascade winner goes through idle
  wire chain = hold_mode && !win[2] && (win[1:0] != cur_q)
               && (mode_q[win[1:0]][MD_TM_HI:MD_TM_LO] != TM_CASCADE);

  // service ends after this transfer
  logic svc_end;
  always_comb
  begin
    svc_end = terminal;
    if (tmode == TM_SINGLE || (soft_cur && tmode == TM_DEMAND)) // [RULE12]
      svc_end = 1'b1;
    else if (tmode == TM_DEMAND && !soft_cur && !rq_q[cur_q])
      svc_end = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer
  wire [AW-1:0] step = is_word ? AW'(2) : AW'(1); // [RULE1]
  wire [AW-1:0] cur_a = caddr_q[cur_q];
  wire [AW-1:0] next_a = mode_q[cur_q][MD_DIR] ? cur_a - step : cur_a + step;
  wire carry8 = next_a[AW-1:8] != cur_a[AW-1:8]; // [RULE7]
  wire finish = (st_q == ST_S4);

  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      st_q    <= ST_IDLE;
      cur_q   <= 2'h0;
      last_q  <= 2'h3;
      first_q <= 1'b1;
      gap_q   <= 2'h0;
    end
    else
    begin
      case (st_q)
        ST_IDLE:
          if (!win[2])
          begin
            cur_q   <= win[1:0];
            first_q <= 1'b1;
            st_q    <= ST_HOLD;
          end
        ST_HOLD:
          if (hack_q)
            st_q <= cascade ? ST_CASC : ST_UPPER;
        ST_UPPER:
          st_q <= ST_S2;
        ST_S2:
          if (!hack_q)
          begin
            st_q  <= continuous ? ST_WAIT : ST_IDLE; // [RULE20] [RULE21]
            gap_q <= 2'(HOLD_GAP_CYC); // [RULE22]
          end
          else
            st_q <= ST_S3;
        ST_S3:
          st_q <= ST_S4;
        ST_S4:
        begin
          first_q <= 1'b0;
          if (svc_end)
          begin
            last_q <= cur_q; // [RULE16]
            if (chain) // [RULE10]
            begin
              cur_q   <= win[1:0];
              first_q <= 1'b1;
              st_q    <= ST_UPPER;
            end
            else
              st_q <= ST_IDLE; // [RULE23]
          end
          else if (!hack_q)
          begin
            st_q  <= continuous ? ST_WAIT : ST_IDLE; // [RULE20] [RULE21]
            gap_q <= 2'(HOLD_GAP_CYC);
          end
          else if (devctl_q[DC_CMP] && !carry8)
            st_q <= ST_S2; // [RULE5] [RULE7]
          else
            st_q <= ST_UPPER;
        end
        ST_WAIT:
        begin
          if (gap_q != 2'h0)
            gap_q <= gap_q - 2'h1; // [RULE22]
          if (tmode == TM_DEMAND && !cur_req && !soft_cur)
            st_q <= ST_IDLE; // [RULE22]
          else if (gap_q == 2'h0 && hack_q)
            st_q <= ST_UPPER; // [RULE20]
        end
        ST_CASC:
          if (!cur_req && !soft_cur || !hack_q)
          begin
            last_q <= cur_q;
            st_q   <= ST_IDLE; // [RULE19]
          end
        default:
          st_q <= ST_IDLE;
      endcase
    end
  end

  wire casc_end = (st_q == ST_CASC) && (!cur_req && !soft_cur || !hack_q);
  wire svc_done = finish && svc_end;

  ////////////////////////////////////////////////////////////////////////////
  // register file and stepping
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      devctl_q <= '0;
      chsel_q  <= '0;
      soft_q   <= '0;
      mask_q   <= MASK_RESET;
      cntend_q <= '0;
      for (int i = 0; i < NCH; i++)
      begin
        mode_q[i]   <= '0;
        baddr_q[i]  <= '0;
        caddr_q[i]  <= '0;
        bcount_q[i] <= '0;
        ccount_q[i] <= '0;
      end
    end
    else
    begin
      if (wr_en)
      begin
        if (PADDR == OFS_DEVCTL)
          devctl_q <= PWDATA[3:0];
        else if (PADDR == OFS_CHSEL)
          chsel_q <= PWDATA[1:0];
        else if (PADDR == OFS_MODE)
          mode_q[chsel_q] <= PWDATA[7:0];
        else if (PADDR == OFS_BADDR)
        begin
          baddr_q[chsel_q] <= PWDATA[AW-1:0];
          caddr_q[chsel_q] <= PWDATA[AW-1:0];
        end
        else if (PADDR == OFS_BCOUNT)
        begin
          bcount_q[chsel_q] <= PWDATA[CW-1:0];
          ccount_q[chsel_q] <= PWDATA[CW-1:0];
        end
        else if (PADDR == OFS_REQUEST)
          soft_q <= PWDATA[NCH-1:0];
        else if (PADDR == OFS_MASK)
          mask_q <= PWDATA[NCH-1:0];
      end
      if (PSEL && PENABLE && !PWRITE && PADDR == OFS_STATUS)
        cntend_q <= '0;
      // word units start even-aligned unless reached by a hold-mode chain
      if (st_q == ST_HOLD && is_word && cur_a[0])
        caddr_q[cur_q] <= {cur_a[AW-1:1], 1'b0}; // [RULE2]
      if (finish)
      begin
        if (svc_done && terminal && mode_q[cur_q][MD_AUTI])
        begin
          caddr_q[cur_q]  <= baddr_q[cur_q]; // [RULE13]
          ccount_q[cur_q] <= bcount_q[cur_q];
        end
        else
        begin
          caddr_q[cur_q]  <= next_a; // [RULE1]
          ccount_q[cur_q] <= ccount_q[cur_q] - CW'(1);
        end
        if (svc_done && terminal)
        begin
          cntend_q[cur_q] <= 1'b1;
          if (!mode_q[cur_q][MD_AUTI])
            mask_q[cur_q] <= 1'b1; // [RULE14]
        end
      end
      // hardware clear is applied last; a fresh soft write races it
      if (casc_end || (svc_done && !hold_mode))
        soft_q <= '0; // [RULE9] [RULE19]
      else if (svc_done && (soft_cur && (tmode != TM_BLOCK || terminal)))
        soft_q[cur_q] <= 1'b0; // [RULE10] [RULE12]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb read data
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
      PRDATA <= '0;
    else if (PSEL && !PENABLE && !PWRITE)
    begin
      if (PADDR == OFS_DEVCTL)
        PRDATA <= 32'(devctl_q);
      else if (PADDR == OFS_CHSEL)
        PRDATA <= 32'(chsel_q);
      else if (PADDR == OFS_MODE)
        PRDATA <= 32'(mode_q[chsel_q]);
      else if (PADDR == OFS_BADDR)
        PRDATA <= 32'(baddr_q[chsel_q]);
      else if (PADDR == OFS_BCOUNT)
        PRDATA <= 32'(bcount_q[chsel_q]);
      else if (PADDR == OFS_CADDR)
        PRDATA <= 32'(caddr_q[chsel_q]);
      else if (PADDR == OFS_CCOUNT)
        PRDATA <= 32'(ccount_q[chsel_q]);
      else if (PADDR == OFS_REQUEST)
        PRDATA <= 32'(soft_q);
      else if (PADDR == OFS_MASK)
        PRDATA <= 32'(mask_q);
      else if (PADDR == OFS_STATUS)
        PRDATA <= 32'({pending, cntend_q});
      else
        PRDATA <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus outputs
  wire active = (st_q != ST_IDLE) && (st_q != ST_HOLD) && (st_q != ST_CASC);
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      BUS_HOLD_REQUEST        <= 1'b0;
      CHANNEL_ACKNOWLEDGE_PIN <= '0;
      ADDRESS                 <= '0;
      ADDRESS_BIT_ZERO        <= 1'b0;
      UPPER_BYTE_ENABLE_N     <= 1'b1;
      UPPER_ADDRESS_STATE     <= 1'b0;
      BUS_WAIT_STATE          <= 1'b0;
      XFER_STROBE             <= 1'b0;
      TERMINAL_COUNT          <= 1'b0;
    end
    else
    begin
      // hold request drops during the wait gap
      BUS_HOLD_REQUEST <= (st_q != ST_IDLE) && !(st_q == ST_WAIT && gap_q != 2'h0)
                          && !casc_end && !(svc_done && !chain); // [RULE18] [RULE22]
      CHANNEL_ACKNOWLEDGE_PIN <= (active || st_q == ST_CASC) ? NCH'(1) << cur_q : '0; // [RULE18]
      ADDRESS          <= active ? cur_a : '0;
      ADDRESS_BIT_ZERO <= active && cur_a[0];
      // narrow bus keeps enable high; word drives both lanes
      UPPER_BYTE_ENABLE_N <= !(active && devctl_q[DC_WIDE] && (is_word || cur_a[0])); // [RULE4]
      UPPER_ADDRESS_STATE <= (st_q == ST_UPPER); // [RULE7]
      BUS_WAIT_STATE   <= (st_q == ST_WAIT);
      XFER_STROBE      <= (st_q == ST_S3);
      TERMINAL_COUNT   <= finish && zero_cnt;
    end
  end

endmodule
